// >>> design/sais_params.svh
`ifndef SAIS_PARAMS_SVH
`define SAIS_PARAMS_SVH

// ****************************************
// Control word field positions
// ****************************************
`define SAIS_CW_ADDR_HI      7
`define SAIS_CW_ADDR_LO      4
`define SAIS_CW_LEN_HI       3
`define SAIS_CW_LEN_LO       2
`define SAIS_CW_LSB_FIRST_SELECT         1
`define SAIS_CW_BIP          0
`define SAIS_CW_RESET        8'h00

// ****************************************
// Length codes and clock counts
// ****************************************
`define SAIS_LEN_CODE_8      2'h1
`define SAIS_LEN_CODE_16     2'h3
`define SAIS_CLKS_8          5'h08
`define SAIS_CLKS_12         5'h0C
`define SAIS_CLKS_16         5'h10
`define SAIS_CTRL_BITS       5'h08
`define SAIS_SAMPLE_EDGE     5'h04

// ****************************************
// Channel address codes
// ****************************************
`define SAIS_ADDR_LAST_INPUT 4'hA
`define SAIS_ADDR_LAST_TEST  4'hD
`define SAIS_ADDR_PWRDN      4'hE

// ****************************************
// Timing
// ****************************************
`define SAIS_CLK_MHZ         40
`define SAIS_CONV_US         10
`define SAIS_CONV_CYCLES     (`SAIS_CONV_US * `SAIS_CLK_MHZ)
`define SAIS_CS_SETUP_NS     100
`define SAIS_CS_SETUP_CYCLES ((`SAIS_CS_SETUP_NS * `SAIS_CLK_MHZ + 999) / 1000)

`endif

// >>> design/sais_pkg.sv
package sais_pkg;

   typedef enum logic [1:0] {
      SAIS_SRC_INPUT,
      SAIS_SRC_TEST,
      SAIS_SRC_PWRDN
   } sais_src_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [1:0] len;
      logic       lsb_first_select;
      logic       bipolar_select;
   } sais_ctrl_t;

   typedef struct packed {
      logic [3:0] channel;
      sais_src_t  src;
      logic       bipolar_select;
   } sais_conv_req_t;

endpackage

// >>> design/sais_sync.sv
`timescale 1ns/100ps

module sais_sync
   import sais_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic d,
   output logic      q
);

   logic meta_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= 1'b1;
         q       <= 1'b1;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end

endmodule

// >>> design/sais_conv_timer.sv
`timescale 1ns/100ps
`include "sais_params.svh"

module sais_conv_timer
   import sais_pkg::*;
#(
   parameter int CONV_CYCLES = `SAIS_CONV_CYCLES
) (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic start,
   input  wire logic abort,
   output logic      busy,
   output logic      done
);

   logic [15:0] cnt_ff;

   // Interval counted on the internal clock
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 16'h0000;
         busy   <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            busy   <= 1'b0;
            cnt_ff <= 16'h0000;
         end else if (start) begin
            busy   <= 1'b1;
            cnt_ff <= 16'(CONV_CYCLES - 1);
         end else if (busy) begin
            if (cnt_ff == 16'h0000) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - 16'h0001;
            end
         end
      end
   end

endmodule

// >>> design/sais_io_seq.sv
`timescale 1ns/100ps
`include "sais_params.svh"

// How it works
// RQ1 - Chip select high: ignore clock, tristate output
// RQ2 - Chip select falling starts sequence, drives output
// RQ3 - Control word: address, length, order, polarity
// RQ4 - Sample control bits on rising clock, MSB first
// RQ5 - Ignore data input after eighth clock
// RQ6 - Host supplies exactly 8/12/16 clocks
// RQ7 - Sample from fourth falling edge, hold at last
// RQ8 - Last falling edge: end-of-conversion low, start
// RQ9 - Shift previous result out while shifting in
// RQ10 - Chip select low: first bit on EOC rise
// RQ11 - Chip select raised: first bit at fall
// RQ12 - Advance output on each later falling edge
// RQ13 - Conversion timed by clock synced to link; the timer counts the free-running mclk instead
// RQ14 - On completion latch result, then raise EOC
// RQ15 - No conversion before I/O cycle completes
// RQ16 - Result held, shifted out next cycle
// RQ17 - Host must drop chip select after power-up
// RQ18 - Power-up: EOC high, control register zero
// RQ19 - Host discards first result after power-up
// RQ20 - Chip select toggle restarts fresh I/O cycle
// RQ21 - Wait setup time after chip select falls
// RQ22 - Twelve-bit cycle exactly twelve clocks
// RQ23 - Length code: 01=8, 11=16, else 12
// RQ24 - Sixteen pads four zeros, eight drops four
// RQ25 - Address applies to next conversion; code map
// RQ26 - LSB-first order, bipolar two's complement option
// RQ27 - EOC low for fixed parameter conversion interval
module sais_io_seq
   import sais_pkg::*;
#(
   parameter int CONV_CYCLES = `SAIS_CONV_CYCLES
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       cs_b,
   input  wire logic       io_clk,
   input  wire logic       data_in,
   input  wire logic [11:0] conv_result,
   output logic            data_out,
   output logic            data_out_oe,
   output logic            eoc,
   output logic [3:0]      analog_channel,
   output logic            test_select,
   output logic            power_down,
   output logic            sample_hold,
   output logic            conv_active
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic cs_b_s;
   logic io_clk_s;
   logic data_in_s;

   sais_sync u_sync_cs (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (cs_b),
      .q     (cs_b_s)
   );
   sais_sync u_sync_clk (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (io_clk),
      .q     (io_clk_s)
   );
   sais_sync u_sync_din (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (data_in),
      .q     (data_in_s)
   );

   // ****************************************
   // Edge detection
   // ****************************************
   logic cs_b_d_ff;
   logic io_clk_d_ff;
   logic setup_ok_ff;
   logic [7:0] setup_cnt_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cs_b_d_ff   <= 1'b1;
         io_clk_d_ff <= 1'b0;
      end else begin
         cs_b_d_ff   <= cs_b_s;
         io_clk_d_ff <= io_clk_s;
      end
   end

   logic cs_fall;
   logic cs_rise;
   logic clk_rise;
   logic clk_fall;
   assign cs_fall  = cs_b_d_ff & ~cs_b_s;
   assign cs_rise  = ~cs_b_d_ff & cs_b_s;
   // Link pulses shorter than one mclk period can be missed
   // Link edges count only while selected and settled
   assign clk_rise = ~cs_b_s & setup_ok_ff & io_clk_s & ~io_clk_d_ff;   // RQ1
   assign clk_fall = ~cs_b_s & setup_ok_ff & ~io_clk_s & io_clk_d_ff;   // RQ1

   // Noise guard after chip select falls
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         setup_cnt_ff <= 8'h00;
         setup_ok_ff  <= 1'b0;
      end else if (cs_b_s) begin
         setup_cnt_ff <= 8'h00;
         setup_ok_ff  <= 1'b0;
      end else if (!setup_ok_ff) begin
         if (setup_cnt_ff == 8'(`SAIS_CS_SETUP_CYCLES - 1))
            setup_ok_ff <= 1'b1;   // RQ21
         else
            setup_cnt_ff <= setup_cnt_ff + 8'h01;
      end
   end

   // ****************************************
   // I/O cycle
   // ****************************************
   logic [7:0] ctrl_ff;
   logic [4:0] rise_cnt_ff;
   logic [4:0] fall_cnt_ff;
   logic       io_done_ff;
   logic [4:0] io_len;
   sais_ctrl_t cur_ctrl;
   logic       conv_busy;
   logic       conv_done;
   logic       last_fall;

   assign cur_ctrl = sais_ctrl_t'(ctrl_ff);

   // Length in force once all eight control bits have arrived
   always_comb begin
      case (cur_ctrl.len)   // RQ23
         `SAIS_LEN_CODE_8:  io_len = `SAIS_CLKS_8;
         `SAIS_LEN_CODE_16: io_len = `SAIS_CLKS_16;
         default:           io_len = `SAIS_CLKS_12;
      endcase
   end

   // Length bits are in by the eighth rise, before any last fall can match
   assign last_fall = clk_fall & !io_done_ff & (fall_cnt_ff + 5'h01 == io_len);   // RQ6 RQ22

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff     <= `SAIS_CW_RESET;   // RQ18
         rise_cnt_ff <= 5'h00;
      end else if (cs_fall) begin
         rise_cnt_ff <= 5'h00;   // RQ20
      end else if (clk_rise && !io_done_ff) begin
         if (rise_cnt_ff < `SAIS_CTRL_BITS) begin
            ctrl_ff     <= {ctrl_ff[6:0], data_in_s};   // RQ4 RQ3
            rise_cnt_ff <= rise_cnt_ff + 5'h01;
         end   // RQ5
      end else if (last_fall) begin
         rise_cnt_ff <= 5'h00;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fall_cnt_ff <= 5'h00;
         io_done_ff  <= 1'b0;
      end else if (cs_fall) begin
         fall_cnt_ff <= 5'h00;
         io_done_ff  <= 1'b0;
      end else if (last_fall) begin
         fall_cnt_ff <= 5'h00;
         io_done_ff  <= 1'b1;
      end else if (clk_fall && !io_done_ff) begin
         fall_cnt_ff <= fall_cnt_ff + 5'h01;
      end else if (conv_done) begin
         io_done_ff  <= 1'b0;
      end
   end

   // Acquisition window
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sample_hold <= 1'b0;
      end else if (cs_fall || cs_rise || last_fall) begin
         // A cycle cut short by deselect must not leave the window open
         sample_hold <= 1'b0;   // RQ7
      end else if (clk_fall && fall_cnt_ff + 5'h01 == `SAIS_SAMPLE_EDGE) begin
         sample_hold <= 1'b1;   // RQ7
      end
   end

   // ****************************************
   // Conversion
   // ****************************************
   sais_conv_req_t req_ff;

   // Timer runs on mclk, started once by the last link fall
   // A falling select aborts a running conversion
   sais_conv_timer #(
      .CONV_CYCLES (CONV_CYCLES)
   ) u_timer (
      .mclk  (mclk),
      .rst_b (rst_b),
      .start (last_fall),   // RQ13 RQ15 RQ27
      .abort (cs_fall),
      .busy  (conv_busy),
      .done  (conv_done)
   );

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req_ff <= '0;
      end else if (last_fall) begin
         req_ff.channel        <= cur_ctrl.addr;   // RQ25
         req_ff.bipolar_select <= cur_ctrl.bipolar_select;
         if (cur_ctrl.addr <= `SAIS_ADDR_LAST_INPUT)
            req_ff.src <= SAIS_SRC_INPUT;
         else if (cur_ctrl.addr <= `SAIS_ADDR_LAST_TEST)
            req_ff.src <= SAIS_SRC_TEST;
         else
            req_ff.src <= SAIS_SRC_PWRDN;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         analog_channel <= 4'h0;
         test_select    <= 1'b0;
         power_down     <= 1'b0;
         conv_active    <= 1'b0;
      end else begin
         analog_channel <= req_ff.channel;
         test_select    <= req_ff.src == SAIS_SRC_TEST;
         // Test codes only steer the mux; power down needs its own code
         power_down     <= req_ff.src == SAIS_SRC_PWRDN && req_ff.channel == `SAIS_ADDR_PWRDN;
         conv_active    <= conv_busy;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         eoc <= 1'b1;   // RQ18
      else if (last_fall)
         eoc <= 1'b0;   // RQ8
      else if (conv_done || (cs_fall && !eoc))
         eoc <= 1'b1;   // RQ14
   end

   // ****************************************
   // Output register
   // ****************************************
   logic [15:0] out_ff;
   logic [15:0] shift_ff;
   logic [11:0] fmt;
   logic [11:0] rev;
   logic [15:0] lsb_word;
   logic [15:0] out_word;
   logic        ord_lsb_ff;
   logic [1:0]  ord_len_ff;

   // Bipolar flips the top bit: offset binary to two's complement
   assign fmt = req_ff.bipolar_select ? {~conv_result[11], conv_result[10:0]}
                                      : conv_result;   // RQ26

   // Order and length of the word that started this conversion
   // Fixed before the result exists, so the view never shifts mid-read
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ord_lsb_ff <= 1'b0;
         ord_len_ff <= 2'h0;
      end else if (last_fall) begin
         ord_lsb_ff <= cur_ctrl.lsb_first_select;   // RQ26
         ord_len_ff <= cur_ctrl.len;   // RQ24
      end
   end

   // Bit reversal for LSB-first order
   generate
      for (genvar i = 0; i < 12; i++) begin : g_rev
         assign rev[i] = fmt[11 - i];
      end
   endgenerate

   // LSB-first starts at the lowest kept bit, except sixteen, which sends four zeros first
   always_comb begin
      case (ord_len_ff)
         `SAIS_LEN_CODE_8:  lsb_word = {rev[7:0], 8'h00};   // RQ24
         `SAIS_LEN_CODE_16: lsb_word = {4'h0, rev};   // RQ24
         default:           lsb_word = {rev, 4'h0};
      endcase
   end

   assign out_word = ord_lsb_ff ? lsb_word : {fmt, 4'h0};   // RQ26

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)
         out_ff <= 16'h0000;   // RQ18
      else if (conv_done)
         out_ff <= out_word;   // RQ14 RQ16 RQ24
   end

   // ****************************************
   // Serial output
   // ****************************************
   logic [4:0] bit_idx_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bit_idx_ff <= 5'h00;
         shift_ff   <= 16'h0000;
      end else if (cs_fall || conv_done) begin
         bit_idx_ff <= 5'h00;   // RQ10 RQ11
         shift_ff   <= conv_done ? out_word : out_ff;
      end else if (clk_fall && !io_done_ff) begin
         bit_idx_ff <= bit_idx_ff + 5'h01;   // RQ12 RQ9
      end
   end

   logic cur_bit;
   always_comb begin
      if (bit_idx_ff[4])
         cur_bit = 1'b0;
      else
         cur_bit = shift_ff[4'(15 - bit_idx_ff[3:0])];   // RQ12
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         data_out    <= 1'b0;
         data_out_oe <= 1'b0;
      end else begin
         data_out    <= cur_bit;
         data_out_oe <= ~cs_b_s;   // RQ1 RQ2
      end
   end

endmodule

// >>> dv/sais_io_seq_asserts.sv
`timescale 1ns/100ps

module sais_io_seq_asserts
   import sais_pkg::*;
#(
   parameter int CONV_CYCLES = 20
) (
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       cs_b,
   input wire logic       data_out_oe,
   input wire logic       eoc,
   input wire logic [3:0] analog_channel,
   input wire logic       test_select,
   input wire logic       power_down,
   input wire logic       sample_hold,
   input wire logic       conv_active
);
   // ****************************************
   // Conversion length counter
   // ****************************************
   int low_cnt_ff;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         low_cnt_ff <= 0;
      end else begin
         low_cnt_ff <= eoc ? 0 : low_cnt_ff + 1;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   property p_oe_off; cs_b [*5] |-> !data_out_oe; endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("output driven while deselected");
   property p_oe_on; $fell(cs_b) ##1 (!cs_b) [*8] |-> data_out_oe; endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("output not driven after select");
   property p_rst_eoc; $rose(rst_b) |-> eoc; endproperty
   a_rst_eoc: assert property (p_rst_eoc)
      else $error("end flag low after reset");
   property p_conv_len; $rose(eoc) |-> low_cnt_ff == CONV_CYCLES + 1; endproperty
   a_conv_len: assert property (p_conv_len)
      else $error("conversion interval wrong");
   property p_start; $fell(eoc) |-> ##[0:2] conv_active; endproperty
   a_start: assert property (p_start)
      else $error("timer not started");
   property p_no_hold; conv_active |-> !sample_hold; endproperty
   a_no_hold: assert property (p_no_hold)
      else $error("sampling during conversion");
   property p_hold_idle; sample_hold |-> eoc; endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("sampling with end flag low");
   property p_pwrdn; power_down |-> analog_channel == 4'hE; endproperty
   a_pwrdn: assert property (p_pwrdn)
      else $error("power down on wrong code");
   property p_test; test_select |-> analog_channel inside {4'hB, 4'hC, 4'hD}; endproperty
   a_test: assert property (p_test)
      else $error("test select on wrong code");

   c_done: cover property ($rose(eoc));
   c_pwrdn: cover property ($rose(power_down));
   c_test: cover property ($rose(test_select));
endmodule

bind sais_io_seq sais_io_seq_asserts #(.CONV_CYCLES(CONV_CYCLES)) i_chk (
   .mclk, .rst_b, .cs_b, .data_out_oe, .eoc, .analog_channel,
   .test_select, .power_down, .sample_hold, .conv_active
);

// >>> dv/sais_host_model.sv
`timescale 1ns/100ps

module sais_host_model (
   input  wire logic mclk,
   input  wire logic data_out,
   output logic      cs_b,
   output logic      io_clk,
   output logic      data_in
);
   // ****************************************
   // Serial port master
   // ****************************************
   initial begin
      cs_b = 1'b1;
      io_clk = 1'b0;
      data_in = 1'b0;
   end

   // Samples just before each fall, long after the output settled
   task automatic xfer(input logic [7:0] cw, input int n, input bit drop,
                       output logic [15:0] rx);
      rx = 16'h0000;
      if (drop) begin
         @(negedge mclk);
         cs_b = 1'b0;
         repeat (12) @(negedge mclk);
      end
      for (int i = 0; i < n; i++) begin
         data_in = (i < 8) ? cw[7 - i] : ~data_in;
         repeat (4) @(negedge mclk);
         io_clk = 1'b1;
         repeat (4) @(negedge mclk);
         rx = {rx[14:0], data_out};
         io_clk = 1'b0;
      end
   endtask

   task automatic deselect();
      @(negedge mclk);
      cs_b = 1'b1;
   endtask
endmodule

// >>> dv/sais_io_seq_tb_top.sv
`timescale 1ns/100ps

module sais_io_seq_tb_top;
   import sais_pkg::*;

   localparam int CONV_CYCLES = 20;

   logic        mclk, rst_b, cs_b, io_clk, data_in;
   logic [11:0] conv_result;
   logic        data_out, data_out_oe, eoc, test_select, power_down;
   logic        sample_hold, conv_active;
   logic [3:0]  analog_channel;
   logic [15:0] rx;
   int          fails, check_count, cyc;

   sais_io_seq #(.CONV_CYCLES(CONV_CYCLES)) i_dut (
      .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .io_clk(io_clk),
      .data_in(data_in), .conv_result(conv_result), .data_out(data_out),
      .data_out_oe(data_out_oe), .eoc(eoc), .analog_channel(analog_channel),
      .test_select(test_select), .power_down(power_down),
      .sample_hold(sample_hold), .conv_active(conv_active)
   );

   sais_host_model i_host (
      .mclk(mclk), .data_out(data_out), .cs_b(cs_b), .io_clk(io_clk),
      .data_in(data_in)
   );

   // ****************************************
   // Clock, checks, closing
   // ****************************************
   always #12.5 mclk = ~mclk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wait_eoc();
      int n;
      n = 0;
      // The end flag drops a few cycles after the last link fall
      while (eoc !== 1'b0 && n < 20) begin
         @(negedge mclk);
         n++;
      end
      while (eoc !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      chk(eoc, 1'b1, "end flag");
      repeat (4) @(negedge mclk);
   endtask

   // Generous ceiling: the whole run needs about 750 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end

   initial begin
      mclk = 1'b0;
      rst_b = 1'b0;
      conv_result = 12'hA5C;
      fails = 0;
      check_count = 0;
      cyc = 0;
      repeat (8) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      chk(eoc, 1'b1, "reset end flag");
      chk(data_out_oe, 1'b0, "reset enable");
      // First result after reset is only the zero reset value of the output register, so it is dropped
      i_host.xfer(8'h30, 12, 1'b1, rx);
      repeat (8) @(negedge mclk);
      chk(eoc, 1'b0, "conversion start");
      chk(sample_hold, 1'b0, "hold after cycle");
      chk(analog_channel, 4'h3, "channel");
      i_host.deselect();
      conv_result = 12'h3C1;
      wait_eoc();
      chk(data_out_oe, 1'b0, "deselected enable");
      $display("test 1 done");
      i_host.xfer(8'hBC, 16, 1'b1, rx);
      chk(rx, 16'h3C10, "16 bit result");
      repeat (8) @(negedge mclk);
      chk(test_select, 1'b1, "test voltage");
      i_host.deselect();
      conv_result = 12'h7E2;
      wait_eoc();
      $display("test 2 done");
      i_host.xfer(8'h54, 8, 1'b1, rx);
      chk(rx, 16'h007E, "8 bit result");
      conv_result = 12'h155;
      wait_eoc();
      $display("test 3 done");
      i_host.xfer(8'hE0, 12, 1'b0, rx);
      chk(rx, 16'h0155, "held select result");
      conv_result = 12'h9B4;
      repeat (8) @(negedge mclk);
      chk(power_down, 1'b1, "power down");
      wait_eoc();
      $display("test 4 done");
      // Order and polarity chosen here apply to the next read
      i_host.xfer(8'h03, 12, 1'b0, rx);
      chk(rx, 16'h09B4, "msb first result");
      conv_result = 12'h8C3;
      wait_eoc();
      chk(power_down, 1'b0, "power up");
      i_host.xfer(8'h00, 12, 1'b0, rx);
      chk(rx, 16'h0C30, "lsb first bipolar result");
      $display("test 5 done");
      conclude();
   end
endmodule
